// file: rtl/lfsb_pkg.sv
// Constants for the load fault status bank
package lfsb_pkg;
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned RW_BIT        = 7;
  localparam logic [4:0]  ADDR_OC_UPPER = 5'b01110;
  localparam logic [4:0]  ADDR_OL_LOWER = 5'b00001;
  localparam logic [4:0]  ADDR_OL_UPPER = 5'b10001;
  localparam int unsigned ADDR_LSB      = 2;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;
endpackage

// file: rtl/lfsb_load_fault_status_bank.sv
// Latched load fault status registers with SPI slave; a full frame with address bit 7 set clears
`timescale 1ns/1ns
module lfsb_load_fault_status_bank (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  input  wire logic [7:0]  oc_high_i,
  input  wire logic [7:0]  oc_low_i,
  input  wire logic [7:0]  ol_high_i,
  input  wire logic [7:0]  ol_low_i,
  output logic      [7:0]  high_side_off_o,
  output logic      [7:0]  low_side_off_o,
  output logic             global_load_error_o
);
  typedef enum logic [1:0] {LFSB_IDLE, LFSB_ADDR, LFSB_DATA} lfsb_state_t;

  lfsb_state_t state_q;
  logic [7:0]  overcurrent_upper_bridges_reg_q;
  logic [7:0]  open_load_lower_bridges_reg_q;
  logic [7:0]  open_load_upper_bridges_reg_q;
  logic [7:0]  oc_lower_q;
  logic        sclk_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_in_q;
  logic [7:0]  shift_out_q;
  logic [7:0]  addr_q;
  logic        clr_oc_u;
  logic        clr_ol_l;
  logic        clr_ol_u;
  logic        rise;
  logic        fall;
  logic        frame_end;

  // Top bit of the 5-bit address field; must precede the functions
  localparam int unsigned ADDR_FIELD_HI = lfsb_pkg::ADDR_LSB + 4;

  // Pack one 4-bridge group: high side on odd bit, low side on even bit
  function automatic logic [7:0] pack4(input logic [3:0] hi_side,
                                       input logic [3:0] lo_side);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 4; i++) begin
      r[2*i+1] = hi_side[i];
      r[2*i]   = lo_side[i];
    end
    return r;
  endfunction

  function automatic logic [7:0] reg_mux(input logic [7:0] a);
    logic [4:0] f;
    f = a[ADDR_FIELD_HI:lfsb_pkg::ADDR_LSB];
    if (f == lfsb_pkg::ADDR_OC_UPPER) begin
      return overcurrent_upper_bridges_reg_q;
    end
    else if (f == lfsb_pkg::ADDR_OL_LOWER) begin
      return open_load_lower_bridges_reg_q;
    end
    else if (f == lfsb_pkg::ADDR_OL_UPPER) begin
      return open_load_upper_bridges_reg_q;
    end
    return lfsb_pkg::UNMAPPED_DATA;
  endfunction

  assign rise      = spi_sclk_i & ~sclk_q;
  assign fall      = ~spi_sclk_i & sclk_q;
  // Clear only at the last (16th) rising edge of a full frame; short frames are dropped
  assign frame_end = (state_q == LFSB_DATA) && rise &&
                     (bit_cnt_q == 4'(lfsb_pkg::FRAME_BITS - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sclk_q <= 1'b0;
    end
    else begin
      sclk_q <= spi_sclk_i;
    end
  end

  // Frame sequencer, mode 0: sample on rise, shift on fall
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_q     <= LFSB_IDLE;
      bit_cnt_q   <= 4'h0;
      shift_in_q  <= 8'h00;
      shift_out_q <= 8'h00;
      addr_q      <= 8'h00;
    end
    else if (spi_cs_n_i) begin
      state_q   <= LFSB_IDLE;
      bit_cnt_q <= 4'h0;
    end
    else begin
      case (state_q)
        LFSB_IDLE: begin
          state_q   <= LFSB_ADDR;
          bit_cnt_q <= 4'h0;
        end
        LFSB_ADDR: begin
          if (rise) begin
            shift_in_q <= {shift_in_q[6:0], spi_mosi_i};
            bit_cnt_q  <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) begin
              addr_q      <= {shift_in_q[6:0], spi_mosi_i};
              shift_out_q <= reg_mux({shift_in_q[6:0], spi_mosi_i});
              state_q     <= LFSB_DATA;
            end
          end
        end
        LFSB_DATA: begin
          if (rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (frame_end) begin
              state_q <= LFSB_IDLE;
            end
          end
          else if (fall && bit_cnt_q != 4'h8) begin
            shift_out_q <= {shift_out_q[6:0], 1'b0};
          end
        end
        default: state_q <= LFSB_IDLE;
      endcase
    end
  end

  always_comb begin
    spi_miso_oe_o = ~spi_cs_n_i;
    spi_miso_o    = (state_q == LFSB_DATA) ? shift_out_q[7] : 1'b0;
  end

  // Clear decode; a read keeps the flags untouched
  always_comb begin
    logic [4:0] f;
    f        = addr_q[ADDR_FIELD_HI:lfsb_pkg::ADDR_LSB];
    clr_oc_u = frame_end && addr_q[lfsb_pkg::RW_BIT] &&
               f == lfsb_pkg::ADDR_OC_UPPER;
    clr_ol_l = frame_end && addr_q[lfsb_pkg::RW_BIT] &&
               f == lfsb_pkg::ADDR_OL_LOWER;
    clr_ol_u = frame_end && addr_q[lfsb_pkg::RW_BIT] &&
               f == lfsb_pkg::ADDR_OL_UPPER;
  end

  // Set wins over clear; only reset and the clear decode clear a flag
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      overcurrent_upper_bridges_reg_q <= lfsb_pkg::FLAGS_RESET;
      open_load_lower_bridges_reg_q   <= lfsb_pkg::FLAGS_RESET;
      open_load_upper_bridges_reg_q   <= lfsb_pkg::FLAGS_RESET;
    end
    else begin
      overcurrent_upper_bridges_reg_q <=
        (clr_oc_u ? 8'h00 : overcurrent_upper_bridges_reg_q) |
        pack4(oc_high_i[7:4], oc_low_i[7:4]);
      open_load_lower_bridges_reg_q <=
        (clr_ol_l ? 8'h00 : open_load_lower_bridges_reg_q) |
        pack4(ol_high_i[3:0], ol_low_i[3:0]);
      open_load_upper_bridges_reg_q <=
        (clr_ol_u ? 8'h00 : open_load_upper_bridges_reg_q) |
        pack4(ol_high_i[7:4], ol_low_i[7:4]);
    end
  end

  // Bridges 1-4 latch here for shutdown; their register lies outside
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      oc_lower_q <= 8'h00;
    end
    else begin
      oc_lower_q <= oc_lower_q | pack4(oc_high_i[3:0], oc_low_i[3:0]);
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      high_side_off_o[i]   = oc_lower_q[2*i+1];
      low_side_off_o[i]    = oc_lower_q[2*i];
      high_side_off_o[i+4] = overcurrent_upper_bridges_reg_q[2*i+1];
      low_side_off_o[i+4]  = overcurrent_upper_bridges_reg_q[2*i];
    end
    global_load_error_o = |{overcurrent_upper_bridges_reg_q,
                            open_load_lower_bridges_reg_q,
                            open_load_upper_bridges_reg_q};
  end

  a_oc_high_sets: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    oc_high_i[7] |=> overcurrent_upper_bridges_reg_q[7] &&
                     high_side_off_o[7])
    else $error("high side overcurrent not latched");
  a_oc_low_sets: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    oc_low_i[4] |=> overcurrent_upper_bridges_reg_q[0] &&
                    low_side_off_o[4])
    else $error("low side overcurrent not latched");
  a_ol_sets: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    ol_low_i[3] |=> open_load_lower_bridges_reg_q[6])
    else $error("open load not latched");
  a_no_self_clear: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    open_load_upper_bridges_reg_q[5] && !clr_ol_u
      |=> open_load_upper_bridges_reg_q[5])
    else $error("flag cleared without command");
  a_clear_works: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    clr_ol_l && ol_high_i[3:0] == 4'h0 && ol_low_i[3:0] == 4'h0
      |=> open_load_lower_bridges_reg_q == 8'h00)
    else $error("clear command ignored");
  a_set_beats_clr: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    clr_oc_u && oc_high_i[5] |=> overcurrent_upper_bridges_reg_q[3])
    else $error("fault lost on clear");
  a_le_or: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    global_load_error_o == (overcurrent_upper_bridges_reg_q != 8'h00 ||
      open_load_lower_bridges_reg_q != 8'h00 ||
      open_load_upper_bridges_reg_q != 8'h00))
    else $error("load error not the OR of flags");
  a_reset_zero: assert property (@(posedge clk_sys_i)
    !reset_n_i |=> open_load_upper_bridges_reg_q == 8'h00 &&
                   overcurrent_upper_bridges_reg_q == 8'h00)
    else $error("flags not zero after reset");

  c_clear_oc: cover property (@(posedge clk_sys_i) clr_oc_u);
  c_clear_ol: cover property (@(posedge clk_sys_i) clr_ol_u);
  c_le_up: cover property (@(posedge clk_sys_i) $rose(global_load_error_o));
  c_read: cover property (@(posedge clk_sys_i)
    frame_end && !addr_q[lfsb_pkg::RW_BIT]);
endmodule

// file: verification/lfsb_spi_master.sv
// SPI master model sending address and data byte frames
`timescale 1ns/1ns
module lfsb_spi_master (
  input  wire logic clk_sys_i,
  input  wire logic spi_miso_i,
  output logic      spi_cs_n_o,
  output logic      spi_sclk_o,
  output logic      spi_mosi_o
);
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_mosi_o = 1'b0;
  end
  // Three clk per sclk level, above the two clk minimum
  task automatic half();
    repeat (3) @(posedge clk_sys_i);
  endtask
  // Fewer than 16 bits models an aborted frame
  task automatic xfer(input logic [7:0] a, input int n,
                      output logic [7:0] d);
    logic [15:0] sh;
    sh = {a, 8'h00};
    d = 8'h00;
    @(posedge clk_sys_i);
    spi_cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_mosi_o <= sh[15 - i];
      half();
      if (i >= 8) d = {d[6:0], spi_miso_i};
      spi_sclk_o <= 1'b1;
      half();
      spi_sclk_o <= 1'b0;
    end
    half();
    spi_cs_n_o <= 1'b1;
    // Released line must not keep the last bit
    spi_mosi_o <= ~spi_mosi_o;
    half();
  endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the load fault status bank
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [7:0] och;
    logic [7:0] ocl;
    logic [7:0] olh;
    logic [7:0] oll;
    logic [7:0] adr;
    logic [7:0] flg;
  } lfsb_row_t;
  lfsb_row_t  rows [6] = '{
    '{8'h80, 8'h00, 8'h00, 8'h00, 8'hb8, 8'h80},
    '{8'h00, 8'h10, 8'h00, 8'h00, 8'hbb, 8'h01},
    '{8'h00, 8'h00, 8'h01, 8'h00, 8'h84, 8'h02},
    '{8'h00, 8'h00, 8'h00, 8'h08, 8'h84, 8'h40},
    '{8'h00, 8'h00, 8'h40, 8'h00, 8'hc4, 8'h20},
    '{8'h00, 8'h00, 8'h00, 8'h10, 8'hc4, 8'h01}};
  logic       clk_sys_i;
  logic       reset_n_i = 1'b0;
  logic       cs_n, sclk, mosi, miso;
  logic [7:0] och, ocl, olh, oll, hi_off, lo_off, d;
  logic       gle, oe;
  int         errors = 0;
  int         n_tests = 0;
  int         cycles = 0;
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  lfsb_load_fault_status_bank uut (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe),
    .oc_high_i(och), .oc_low_i(ocl), .ol_high_i(olh), .ol_low_i(oll),
    .high_side_off_o(hi_off), .low_side_off_o(lo_off),
    .global_load_error_o(gle));
  lfsb_spi_master spi (.clk_sys_i(clk_sys_i), .spi_miso_i(miso),
    .spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_mosi_o(mosi));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drive(input lfsb_row_t r);
    och <= r.och;
    ocl <= r.ocl;
    olh <= r.olh;
    oll <= r.oll;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 3000 cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  // Output enable must follow chip select through every frame
  always @(posedge clk_sys_i)
    if (!cs_n) check(oe, 1'b1);
  initial begin
    drive('0);
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    foreach (rows[k]) begin
      @(posedge clk_sys_i);
      drive(rows[k]);
      @(posedge clk_sys_i);
      drive('0);
      repeat (2) @(posedge clk_sys_i);
      check(hi_off & rows[k].och, rows[k].och);
      check(lo_off & rows[k].ocl, rows[k].ocl);
      check(gle, 1'b1);
      repeat (20) @(posedge clk_sys_i);
      spi.xfer(rows[k].adr & 8'h7f, 16, d);
      check(d, rows[k].flg);
      spi.xfer(rows[k].adr, 16, d);
      check(d, rows[k].flg);
      spi.xfer(rows[k].adr, 16, d);
      check(d, 8'h00);
      check(gle, 1'b0);
      $display("row %0d done", k);
    end
    // Clear while the fault is still present
    drive(lfsb_row_t'{8'h20, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00});
    spi.xfer(8'hc4, 16, d);
    spi.xfer(8'h44, 16, d);
    check(d, 8'h20);
    spi.xfer(8'hb8, 16, d);
    spi.xfer(8'h38, 16, d);
    check(d, 8'h08);
    check(hi_off, 8'h20);
    drive('0);
    spi.xfer(8'hc4, 10, d);
    spi.xfer(8'h44, 16, d);
    check(d, 8'h20);
    spi.xfer(8'h7c, 16, d);
    check(d, 8'h00);
    $display("abort, priority, unmapped done");
    reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    check(gle, 1'b0);
    check(hi_off | lo_off, 8'h00);
    check(oe, 1'b0);
    reset_n_i <= 1'b1;
    spi.xfer(8'h38, 16, d);
    check(d, 8'h00);
    spi.xfer(8'h04, 16, d);
    check(d, 8'h00);
    spi.xfer(8'h44, 16, d);
    check(d, 8'h00);
    $display("reset done");
    end_of_test();
  end
endmodule
